// ---- pic_defs.svh ----
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// ****************************************
// port addresses
// ****************************************
`define PIC_PRI_CMD_ADDR 8'h20
`define PIC_PRI_DATA_ADDR 8'h21
`define PIC_SEC_CMD_ADDR 8'hA0
`define PIC_SEC_DATA_ADDR 8'hA1

// ****************************************
// command byte fields
// ****************************************
`define PIC_INIT_START_BIT 4
`define PIC_READ_POLL_SEL_BIT 3
`define PIC_ROTATE_BIT 7
`define PIC_SELECT_LEVEL_BIT 6
`define PIC_END_SVC_BIT 5
`define PIC_SPECIAL_MASK_WE_BIT 6
`define PIC_SPECIAL_MASK_BIT 5
`define PIC_POLL_BIT 2
`define PIC_READ_SEL_VALID_BIT 1
`define PIC_READ_SEL_SVC_BIT 0
`define PIC_AUTO_END_BIT 1
`define PIC_SPECIAL_NEST_BIT 4
`define PIC_POLL_FLAG_BIT 7

// ****************************************
// reset and init values
// ****************************************
`define PIC_CASCADE_CH 3'h2
`define PIC_DEFAULT_LEVEL 3'h7
`define PIC_INIT_LOW_PRIO 3'h7
`define PIC_INIT_CASCADE_ID 8'h07
`define PIC_INIT_SEEN 8'hFF

`endif

// ---- pic_pkg.sv ----
package pic_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_rsp_t;

  typedef enum logic [1:0] {
    INIT_DONE = 2'b00,
    INIT_WAIT_BASE = 2'b01,
    INIT_WAIT_CASC = 2'b11,
    INIT_WAIT_MODE = 2'b10
  } init_step_t;

  typedef enum logic {
    ACK_IDLE = 1'b0,
    ACK_WAIT = 1'b1
  } ack_state_t;

  typedef struct packed {
    logic [7:0] req_pend;
    logic [7:0] in_svc;
    logic [7:0] ch_mask;
    logic [7:0] low_seen;
    logic [7:0] prev_in;
    logic [7:0] cascade_id;
    logic [4:0] vec_base;
    logic [2:0] prio_low;
    init_step_t init_step;
    logic auto_end;
    logic special_nest;
    logic rotate_auto;
    logic special_mask;
    logic read_svc;
    logic poll;
  } ctl_t;

  typedef struct packed {
    ctl_t [1:0] ctl;
    ack_state_t ack_st;
    logic [7:0] ack_vec;
    logic int_out;
    byte_rsp_t rd_rsp;
    byte_rsp_t vec_rsp;
  } state_t;

  // first set bit walking from the level after low, wrapping: {found, id}
  function automatic logic [3:0] first_set(input logic [7:0] v,
                                           input logic [2:0] low);
    logic found;
    logic [2:0] id;
    logic [2:0] ch;
    found = 1'b0;
    id = 3'h0;
    for (int i = 0; i < 8; i++) begin
      ch = 3'(low + 3'(i) + 3'h1);
      if (!found && v[ch]) begin
        found = 1'b1;
        id = ch;
      end
    end
    return {found, id};
  endfunction : first_set

endpackage : pic_pkg

// ---- irq_sync.sv ----
`timescale 1ns/1ps
module irq_sync #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage1;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  if (WIDTH < 1) begin : g_chk
    $error("irq_sync: WIDTH must be at least 1");
  end

  // stage1 is read by stage2 only
  always_comb begin
    st_nxt.stage1 = async_in;
    st_nxt.stage2 = st_r.stage1;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stage2;
endmodule : irq_sync

// ---- prio_resolver.sv ----
`timescale 1ns/1ps
module prio_resolver (
  input wire logic [7:0] req,
  input wire logic [7:0] in_svc,
  input wire logic [7:0] equal_ok,
  input wire logic [2:0] prio_low,
  output logic win_valid,
  output logic [2:0] win_id
);
  // walk from highest to lowest priority; a set in-service bit ends the
  // walk, so lower levels stay blocked and an equal level wins only where equal_ok is set
  always_comb begin
    logic stop;
    logic [2:0] ch;
    stop = 1'b0;
    ch = 3'h0;
    win_valid = 1'b0;
    win_id = 3'h0;
    for (int i = 0; i < 8; i++) begin
      ch = 3'(prio_low + 3'(i) + 3'h1);
      if (!stop) begin
        if (req[ch] && (!in_svc[ch] || equal_ok[ch])) begin
          win_valid = 1'b1;
          win_id = ch;
          stop = 1'b1;
        end else if (in_svc[ch]) begin
          stop = 1'b1;
        end
      end
    end
  end
endmodule : prio_resolver

// ---- cascaded_legacy_interrupt_ctrl.sv ----
//
// Functional notes
// (RULE1) command-port write with data bit 4 set starts init; ports 20h, A0h
// (RULE2) next three data-port writes (21h, A1h) are init words two to four
// (RULE3) init start clears mask, resets priority, cascade id 7, status reads
// (RULE4) after init an input needs a low-to-high transition to request
// (RULE5) init word two bits 7:3 form vector bits 7:3, per controller
// (RULE6) software sets only bit 2 of primary cascade word
// (RULE7) cascade win broadcasts code; secondary answers only on id match
// (RULE8) software writes mode word with bit 0 set to both controllers
// (RULE9) fully nested: input 0 highest; acknowledge sets in-service bit
// (RULE10) in-service bit blocks equal and lower levels, higher still interrupt
// (RULE11) special nesting on primary lets secondary raise higher requests
// (RULE12) rotate on end command or rotate in auto mode makes served lowest
// (RULE13) set-priority makes named input lowest; with end bit ends its service
// (RULE14) poll bit freezes requests; next read acts as acknowledge
// (RULE15) poll byte: bit 7 pending flag, bits 2:0 highest level
// (RULE16) trigger mode per input from select inputs: 0 edge, 1 level
// (RULE17) level sources drop request before software ends service
// (RULE18) request gone at first acknowledge returns primary level 7 vector
// (RULE19) non-specific end clears top in-service bit; specific clears named
// (RULE20) auto end on primary performs non-specific end at last acknowledge
// (RULE21) mask bit blocks its input; primary input 2 blocks whole secondary
// (RULE22) special mask entered with both bits one, left with both zero
// (RULE23) vector bits 2:0 carry acknowledged input number
// (RULE24) request bit set even when masked; masked never interrupts
// (RULE25) first acknowledge sets in-service, clears request; second gives vector
// (RULE26) command write bit 4 clear: bit 3 picks priority word or read word
// (RULE27) command read gives request or in-service; data read gives mask
//
`timescale 1ns/1ps
`include "pic_defs.svh"
module cascaded_legacy_interrupt_ctrl (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire pic_pkg::io_req_t io_req,
  input wire logic [15:0] irq_in,
  input wire logic [7:0] primary_trigger_select,
  input wire logic [7:0] secondary_trigger_select,
  input wire logic internal_ack_pulse,
  output logic cpu_interrupt_output,
  output pic_pkg::byte_rsp_t io_rsp,
  output pic_pkg::byte_rsp_t ack_rsp
);
  import pic_pkg::*;

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic port_hit(input logic [7:0] addr, input int k,
                                    input logic data_port);
    logic [7:0] want;
    if (k == 0) begin
      want = data_port ? `PIC_PRI_DATA_ADDR : `PIC_PRI_CMD_ADDR;
    end else begin
      want = data_port ? `PIC_SEC_DATA_ADDR : `PIC_SEC_CMD_ADDR;
    end
    return addr == want;
  endfunction : port_hit

  // in special mask mode a masked in-service level is left alone
  function automatic logic [3:0] top_in_service(input ctl_t c);
    return first_set(c.in_svc & ~(c.special_mask ? c.ch_mask : 8'h00),
                     c.prio_low); // RULE19
  endfunction : top_in_service

  // ****************************************
  // state and submodules
  // ****************************************
  state_t st_r;
  state_t st_nxt;
  logic [15:0] irq_s;
  logic [1:0] res_valid;
  logic [1:0][2:0] res_id;

  irq_sync #(
    .WIDTH(16)
  ) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(irq_in),
    .sync_out(irq_s)
  );

  for (genvar g = 0; g < 2; g++) begin : g_res
    logic [7:0] eq_ok;
    logic [7:0] svc_eff;
    // special nesting lets the cascade level re-win while in service
    assign eq_ok = (g == 0 && st_r.ctl[0].special_nest) ?
                   st_r.ctl[0].cascade_id : 8'h00; // RULE11
    // special mask: unmasked inputs ignore in-service state
    assign svc_eff = st_r.ctl[g].special_mask ? 8'h00 :
                     st_r.ctl[g].in_svc; // RULE22 RULE10
    prio_resolver u_res (
      .req(st_r.ctl[g].req_pend & ~st_r.ctl[g].ch_mask), // RULE21 RULE24
      .in_svc(svc_eff),
      .equal_ok(eq_ok),
      .prio_low(st_r.ctl[g].prio_low),
      .win_valid(res_valid[g]),
      .win_id(res_id[g])
    );
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] raw;
    logic [7:0] trig;
    logic [7:0] d;
    logic [3:0] top;
    logic frozen;
    logic hit_cmd;
    logic hit_data;
    ctl_t c;
    raw = 8'h00;
    trig = 8'h00;
    d = io_req.wdata;
    top = 4'h0;
    frozen = 1'b0;
    hit_cmd = 1'b0;
    hit_data = 1'b0;
    c = '0;
    st_nxt = st_r;
    st_nxt.rd_rsp = '0;
    st_nxt.vec_rsp = '0;

    for (int k = 0; k < 2; k++) begin
      c = st_r.ctl[k];
      // the secondary's request output drives primary cascade input
      if (k == 0) begin
        raw = irq_s[7:0];
        raw[`PIC_CASCADE_CH] = res_valid[1];
        trig = primary_trigger_select;
      end else begin
        raw = irq_s[15:8];
        trig = secondary_trigger_select;
      end
      hit_cmd = port_hit(io_req.addr, k, 1'b0);
      hit_data = port_hit(io_req.addr, k, 1'b1);

      // ********** request capture **********
      // frozen between poll command and read, and between the two
      // acknowledges; inputs are not sampled so no edge is lost
      frozen = c.poll || st_r.ack_st == ACK_WAIT; // RULE14
      if (!frozen) begin
        st_nxt.ctl[k].req_pend = (c.req_pend & ~trig) |
                                 (raw & ~c.prev_in & ~trig) |
                                 (raw & c.low_seen & trig); // RULE16 RULE24
        st_nxt.ctl[k].prev_in = raw;
        st_nxt.ctl[k].low_seen = c.low_seen | ~raw; // RULE4
      end

      // ********** command port writes **********
      if (io_req.wr && hit_cmd) begin
        if (d[`PIC_INIT_START_BIT]) begin
          st_nxt.ctl[k].init_step = INIT_WAIT_BASE; // RULE1 RULE2
          st_nxt.ctl[k].ch_mask = 8'h00; // RULE3
          st_nxt.ctl[k].prio_low = `PIC_INIT_LOW_PRIO; // RULE3
          st_nxt.ctl[k].cascade_id = `PIC_INIT_CASCADE_ID; // RULE3
          st_nxt.ctl[k].special_mask = 1'b0; // RULE3
          st_nxt.ctl[k].read_svc = 1'b0; // RULE3
          st_nxt.ctl[k].req_pend = 8'h00;
          st_nxt.ctl[k].in_svc = 8'h00;
          st_nxt.ctl[k].low_seen = 8'h00; // RULE4
          st_nxt.ctl[k].prev_in = `PIC_INIT_SEEN; // RULE4
          st_nxt.ctl[k].poll = 1'b0;
          st_nxt.ctl[k].rotate_auto = 1'b0;
          st_nxt.ctl[k].auto_end = 1'b0;
          st_nxt.ctl[k].special_nest = 1'b0;
        end else if (!d[`PIC_READ_POLL_SEL_BIT]) begin // RULE26
          top = top_in_service(c);
          if (d[`PIC_END_SVC_BIT] && !d[`PIC_SELECT_LEVEL_BIT]) begin
            if (top[3]) begin
              st_nxt.ctl[k].in_svc[top[2:0]] = 1'b0; // RULE19
              if (d[`PIC_ROTATE_BIT]) begin
                st_nxt.ctl[k].prio_low = top[2:0]; // RULE12
              end
            end
          end else if (d[`PIC_END_SVC_BIT]) begin
            st_nxt.ctl[k].in_svc[d[2:0]] = 1'b0; // RULE19 RULE13
            if (d[`PIC_ROTATE_BIT]) begin
              st_nxt.ctl[k].prio_low = d[2:0]; // RULE13
            end
          end else if (d[`PIC_SELECT_LEVEL_BIT]) begin
            if (d[`PIC_ROTATE_BIT]) begin
              st_nxt.ctl[k].prio_low = d[2:0]; // RULE13
            end
          end else begin
            st_nxt.ctl[k].rotate_auto = d[`PIC_ROTATE_BIT]; // RULE12
          end
        end else begin // RULE26
          if (d[`PIC_READ_SEL_VALID_BIT]) begin
            st_nxt.ctl[k].read_svc = d[`PIC_READ_SEL_SVC_BIT]; // RULE27
          end
          if (d[`PIC_SPECIAL_MASK_WE_BIT] && d[`PIC_SPECIAL_MASK_BIT]) begin
            st_nxt.ctl[k].special_mask = 1'b1; // RULE22
          end else if (!d[`PIC_SPECIAL_MASK_WE_BIT] &&
                       !d[`PIC_SPECIAL_MASK_BIT]) begin
            st_nxt.ctl[k].special_mask = 1'b0; // RULE22
          end
          if (d[`PIC_POLL_BIT]) begin
            st_nxt.ctl[k].poll = 1'b1; // RULE14
          end
        end
      end

      // ********** data port writes **********
      if (io_req.wr && hit_data) begin
        unique case (c.init_step)
          INIT_WAIT_BASE: begin
            st_nxt.ctl[k].vec_base = d[7:3]; // RULE5
            st_nxt.ctl[k].init_step = INIT_WAIT_CASC; // RULE2
          end
          INIT_WAIT_CASC: begin
            st_nxt.ctl[k].cascade_id = d; // RULE7
            st_nxt.ctl[k].init_step = INIT_WAIT_MODE; // RULE2
          end
          INIT_WAIT_MODE: begin
            // automatic end only serves the primary
            st_nxt.ctl[k].auto_end = (k == 0) && d[`PIC_AUTO_END_BIT]; // RULE20
            st_nxt.ctl[k].special_nest = d[`PIC_SPECIAL_NEST_BIT]; // RULE11
            st_nxt.ctl[k].init_step = INIT_DONE; // RULE2
          end
          INIT_DONE: begin
            st_nxt.ctl[k].ch_mask = d; // RULE21
          end
        endcase
      end

      // ********** reads **********
      if (io_req.rd && (hit_cmd || hit_data)) begin
        st_nxt.rd_rsp.valid = 1'b1;
        if (c.poll) begin
          // poll read counts as an acknowledge for this controller
          st_nxt.rd_rsp.data = {res_valid[k], 4'h0, res_id[k]}; // RULE15
          st_nxt.ctl[k].poll = 1'b0;
          if (res_valid[k]) begin
            st_nxt.ctl[k].in_svc[res_id[k]] = 1'b1; // RULE14
            st_nxt.ctl[k].req_pend[res_id[k]] = 1'b0; // RULE14
          end
        end else if (hit_cmd) begin
          st_nxt.rd_rsp.data = c.read_svc ? c.in_svc : c.req_pend; // RULE27
        end else begin
          st_nxt.rd_rsp.data = c.ch_mask; // RULE27
        end
      end
    end

    // ********** acknowledge sequence **********
    if (internal_ack_pulse) begin
      unique case (st_r.ack_st)
        ACK_IDLE: begin
          st_nxt.ack_st = ACK_WAIT;
          // default when the request vanished before the first pulse
          st_nxt.ack_vec = {st_r.ctl[0].vec_base, `PIC_DEFAULT_LEVEL}; // RULE18
          if (res_valid[0]) begin
            st_nxt.ctl[0].in_svc[res_id[0]] = 1'b1; // RULE9 RULE25
            st_nxt.ctl[0].req_pend[res_id[0]] = 1'b0; // RULE25
            if (st_r.ctl[0].cascade_id[res_id[0]]) begin
              // broadcast code is the winning primary level
              if (res_id[0] == st_r.ctl[1].cascade_id[2:0] &&
                  res_valid[1]) begin // RULE7
                st_nxt.ctl[1].in_svc[res_id[1]] = 1'b1; // RULE25
                st_nxt.ctl[1].req_pend[res_id[1]] = 1'b0; // RULE25
                st_nxt.ack_vec = {st_r.ctl[1].vec_base, res_id[1]}; // RULE5
              end
            end else begin
              st_nxt.ack_vec = {st_r.ctl[0].vec_base, res_id[0]}; // RULE23
            end
          end
        end
        ACK_WAIT: begin
          st_nxt.ack_st = ACK_IDLE;
          st_nxt.vec_rsp.valid = 1'b1; // RULE25
          st_nxt.vec_rsp.data = st_r.ack_vec; // RULE5 RULE23
          if (st_r.ctl[0].auto_end) begin
            top = top_in_service(st_r.ctl[0]);
            if (top[3]) begin
              st_nxt.ctl[0].in_svc[top[2:0]] = 1'b0; // RULE20
              if (st_r.ctl[0].rotate_auto) begin
                st_nxt.ctl[0].prio_low = top[2:0]; // RULE12
              end
            end
          end
        end
      endcase
    end

    // masked or blocked requests never reach the processor
    st_nxt.int_out = res_valid[0]; // RULE10 RULE21 RULE24
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cpu_interrupt_output = st_r.int_out;
  assign io_rsp = st_r.rd_rsp;
  assign ack_rsp = st_r.vec_rsp;
endmodule : cascaded_legacy_interrupt_ctrl

// ---- pic_asserts.sv ----
`timescale 1ns/1ps
module pic_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire pic_pkg::io_req_t io_req,
  input wire logic [15:0] irq_in,
  input wire logic [7:0] primary_trigger_select,
  input wire logic [7:0] secondary_trigger_select,
  input wire logic internal_ack_pulse,
  input wire logic cpu_interrupt_output,
  input wire pic_pkg::byte_rsp_t io_rsp,
  input wire pic_pkg::byte_rsp_t ack_rsp
);
  import pic_pkg::*;
  // ****************************************
  // helper state
  // ****************************************
  logic hit, cwr, c, ack_sec_r;
  logic [2:0] quiet_r;
  logic [15:0] irq_r;
  logic [7:0] mexp_r;
  logic [1:0] poll_r;
  logic [1:0][1:0] step_r;
  logic [1:0][4:0] base_r;
  logic [1:0][7:0] mask_r;
  assign hit = io_req.addr[6:1] == 6'h10;
  assign c = io_req.addr[7];
  assign cwr = io_req.wr && hit && !io_req.addr[0];
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_sec_r <= 1'b0;
      quiet_r <= 3'h0;
      irq_r <= 16'h0000;
      mexp_r <= 8'h00;
      poll_r <= 2'h0;
      step_r <= '0;
      base_r <= '0;
      mask_r <= '0;
    end else begin
      irq_r <= irq_in;
      mexp_r <= mask_r[c];
      if (internal_ack_pulse) ack_sec_r <= !ack_sec_r;
      // any of these may legitimately change the interrupt output
      if (irq_in != irq_r || io_req.wr || io_req.rd || internal_ack_pulse)
        quiet_r <= 3'h0;
      else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
      if (cwr && io_req.wdata[4:3] != 2'b00)
        poll_r[c] <= io_req.wdata[4:2] == 3'b011;
      else if (io_req.rd && hit) poll_r[c] <= 1'b0;
      if (cwr && io_req.wdata[4]) begin
        step_r[c] <= 2'h3;
        mask_r[c] <= 8'h00;
      end else if (io_req.wr && hit && io_req.addr[0]) begin
        if (step_r[c] == 2'h0) mask_r[c] <= io_req.wdata;
        else step_r[c] <= step_r[c] - 2'h1;
        if (step_r[c] == 2'h3) base_r[c] <= io_req.wdata[7:3];
      end
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  rd_answer_a: assert property (io_req.rd && hit |=> io_rsp.valid)
    else $error("port read not answered");
  rd_refused_a: assert property (!(io_req.rd && hit) |=> !io_rsp.valid)
    else $error("answer without a port read");
  ack_vector_a: assert property (
    internal_ack_pulse && ack_sec_r |=> ack_rsp.valid)
    else $error("no vector after second acknowledge");
  ack_quiet_a: assert property (
    !(internal_ack_pulse && ack_sec_r) |=> !ack_rsp.valid)
    else $error("vector without second acknowledge");
  vec_base_a: assert property (ack_rsp.valid |->
    ack_rsp.data[7:3] == base_r[0] || ack_rsp.data[7:3] == base_r[1])
    else $error("vector base bits wrong");
  irq_cause_a: assert property (
    $rose(cpu_interrupt_output) |-> quiet_r <= 3'h5)
    else $error("interrupt raised without a cause");
  poll_format_a: assert property (
    io_req.rd && hit && poll_r[c] |=> io_rsp.data[6:3] == 4'h0)
    else $error("poll byte has stray bits");
  mask_read_a: assert property (io_req.rd && hit && io_req.addr[0] &&
    !io_req.wr && !poll_r[c] |=> io_rsp.data == mexp_r)
    else $error("data port read is not the mask");
endmodule : pic_asserts

bind cascaded_legacy_interrupt_ctrl pic_asserts chk (.ref_clk, .rstn,
  .io_req, .irq_in, .primary_trigger_select, .secondary_trigger_select,
  .internal_ack_pulse, .cpu_interrupt_output, .io_rsp, .ack_rsp);

// ---- host_io_model.sv ----
`timescale 1ns/1ps
module host_io_model (
  input wire logic ref_clk,
  output pic_pkg::io_req_t io_req,
  output logic internal_ack_pulse
);
  import pic_pkg::*;
  initial begin
    io_req = '0;
    internal_ack_pulse = 1'b0;
  end
  // ****************************************
  // one access, held across its taking edge
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    io_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
    // released lines must not keep showing the last request
    io_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
  task automatic ack_pair();
    repeat (2) begin
      @(posedge ref_clk);
      #1;
      internal_ack_pulse = 1'b1;
      @(posedge ref_clk);
      #1;
      internal_ack_pulse = 1'b0;
    end
  endtask : ack_pair
endmodule : host_io_model

// ---- tb_cascaded_legacy_interrupt_ctrl.sv ----
`timescale 1ns/1ps
module tb_cascaded_legacy_interrupt_ctrl;
  import pic_pkg::*;
  logic ref_clk, rstn, internal_ack_pulse, cpu_interrupt_output;
  logic [15:0] irq_in;
  logic [7:0] primary_trigger_select, secondary_trigger_select;
  io_req_t io_req;
  byte_rsp_t io_rsp, ack_rsp;
  logic [7:0] io_q[$], ack_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  logic [15:0] init_seq [8] = '{16'h2011, 16'h2108, 16'h2104, 16'h2101,
    16'hA011, 16'hA170, 16'hA102, 16'hA101};
  cascaded_legacy_interrupt_ctrl uut (.ref_clk, .rstn, .io_req, .irq_in,
    .primary_trigger_select, .secondary_trigger_select, .internal_ack_pulse,
    .cpu_interrupt_output, .io_rsp, .ack_rsp);
  host_io_model host (.ref_clk, .io_req, .internal_ack_pulse);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // an answer with nothing queued compares against unknown and fails
  always @(negedge ref_clk) begin
    if (io_rsp.valid === 1'b1)
      chk("io_rsp", io_q.size() ? io_q.pop_front() : 8'hXX, io_rsp.data);
    if (ack_rsp.valid === 1'b1)
      chk("ack_rsp", ack_q.size() ? ack_q.pop_front() : 8'hXX, ack_rsp.data);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    io_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask : rd
  task automatic ack(input logic [7:0] e);
    ack_q.push_back(e);
    host.ack_pair();
  endtask : ack
  task automatic finish_test();
    if (io_q.size() + ack_q.size() != 0) error_cnt++;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic wait_int(input logic l, input int hold);
    int i;
    repeat (hold) @(posedge ref_clk);
    for (i = 0; i < 40 && cpu_interrupt_output !== l; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("cpu_interrupt_output", {7'h00, l}, {7'h00, cpu_interrupt_output});
    if (i == 40) finish_test();
  endtask : wait_int
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    irq_in = 16'h0000;
    primary_trigger_select = 8'h00;
    secondary_trigger_select = 8'h00;
    n = $urandom(65);
    repeat (20) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    wr(8'h21, 8'hFF);
    // primary cascade word has only bit 2 set, mode words set bit 0
    foreach (init_seq[i]) wr(init_seq[i][15:8], init_seq[i][7:0]);
    rd(8'h21, 8'h00);
    rd(8'h20, 8'h00);
    host.xfer(1'b0, 8'h22, 8'h00);
    wr(8'h20, 8'h0B);
    wr(8'hA0, 8'h0B);
    $display("init and status reads done");
    for (int t = 0; t < 8; t++) begin
      n = $urandom % 16;
      if (n == 2) n = 3;
      irq_in[n] = 1'b1;
      wait_int(1'b1, 0);
      ack((n < 8 ? 8'h08 : 8'h70) | 8'(n % 8));
      rd(n < 8 ? 8'h20 : 8'hA0, 8'h01 << (n % 8));
      irq_in[n] = 1'b0;
      if (n >= 8) wr(8'hA0, 8'h20);
      wr(8'h20, 8'h20);
      rd(n < 8 ? 8'h20 : 8'hA0, 8'h00);
    end
    $display("random vectors done");
    irq_in[5] = 1'b1;
    irq_in[3] = 1'b1;
    wait_int(1'b1, 0);
    ack(8'h0B);
    wait_int(1'b0, 8);
    irq_in[1] = 1'b1;
    wait_int(1'b1, 0);
    ack(8'h09);
    wr(8'h20, 8'h20);
    wait_int(1'b0, 8);
    wr(8'h20, 8'h20);
    wait_int(1'b1, 0);
    ack(8'h0D);
    irq_in[5:1] = 5'h00;
    wr(8'h20, 8'h20);
    $display("nesting done");
    wr(8'h21, 8'h24);
    irq_in[5] = 1'b1;
    irq_in[9] = 1'b1;
    wait_int(1'b0, 10);
    wr(8'hA0, 8'h0A);
    rd(8'hA0, 8'h02);
    wr(8'h21, 8'h00);
    wait_int(1'b1, 0);
    ack(8'h71);
    wr(8'hA0, 8'h20);
    wr(8'h20, 8'h20);
    wait_int(1'b1, 0);
    ack(8'h0D);
    irq_in = 16'h0000;
    wr(8'h20, 8'h20);
    $display("masking done");
    wr(8'h20, 8'hC4);
    irq_in[3] = 1'b1;
    irq_in[6] = 1'b1;
    wait_int(1'b1, 0);
    ack(8'h0E);
    wr(8'h20, 8'h66);
    wait_int(1'b1, 0);
    ack(8'h0B);
    irq_in = 16'h0000;
    wr(8'h20, 8'hA0);
    irq_in[4:3] = 2'h3;
    wait_int(1'b1, 0);
    ack(8'h0C);
    wr(8'h20, 8'h20);
    wait_int(1'b1, 0);
    ack(8'h0B);
    irq_in = 16'h0000;
    wr(8'h20, 8'h20);
    wr(8'h20, 8'hC7);
    $display("rotation done");
    irq_in[6] = 1'b1;
    wait_int(1'b1, 0);
    wr(8'h20, 8'h0C);
    rd(8'h20, 8'h86);
    wr(8'h20, 8'h0B);
    rd(8'h20, 8'h40);
    irq_in[6] = 1'b0;
    wr(8'h20, 8'h20);
    ack(8'h0F);
    $display("poll and default vector done");
    primary_trigger_select = 8'h40;
    irq_in[6] = 1'b1;
    wait_int(1'b1, 0);
    ack(8'h0E);
    irq_in[6] = 1'b0;
    // let the dropped level through the synchroniser before ending service
    repeat (4) @(posedge ref_clk);
    wr(8'h20, 8'h20);
    wait_int(1'b0, 8);
    $display("level trigger done");
    wr(8'h20, 8'h68);
    irq_in[3] = 1'b1;
    wait_int(1'b1, 0);
    ack(8'h0B);
    irq_in[5] = 1'b1;
    wait_int(1'b1, 0);
    ack(8'h0D);
    wr(8'h20, 8'h08);
    irq_in = 16'h0000;
    wr(8'h20, 8'h20);
    wr(8'h20, 8'h20);
    rd(8'h20, 8'h00);
    wr(8'h20, 8'h11);
    wr(8'h21, 8'h08);
    wr(8'h21, 8'h04);
    wr(8'h21, 8'h03);
    wr(8'h20, 8'h0B);
    irq_in[4] = 1'b1;
    wait_int(1'b1, 0);
    ack(8'h0C);
    rd(8'h20, 8'h00);
    $display("special mask and auto end done");
    repeat (4) @(posedge ref_clk);
    finish_test();
  end
endmodule : tb_cascaded_legacy_interrupt_ctrl
